// file: shared/cpd_defs.svh
// Register map, field positions and reset values of the preset/direction block
`ifndef CPD_DEFS_SVH
`define CPD_DEFS_SVH

// Bus geometry
`define CPD_ADDR_W 8
`define CPD_DATA_W 32
`define CPD_HYST_W 16

// Register byte offsets
`define CPD_OFS_CTRL 8'h00
`define CPD_OFS_PRESET 8'h04
`define CPD_OFS_HYST 8'h08
`define CPD_OFS_STATUS 8'h0c
`define CPD_OFS_COUNT 8'h10

// Control register bit positions
`define CPD_CTRL_SW 0
`define CPD_CTRL_ZERO 1
`define CPD_CTRL_RISE 2
`define CPD_CTRL_FALL 3
`define CPD_CTRL_INV 4

// Status register bit positions
`define CPD_ST_DONE 0
`define CPD_ST_DIR 1
`define CPD_ST_OVF 2
`define CPD_ST_UNF 3

// Reset values and limits
`define CPD_RST_WORD 32'h0000_0000
`define CPD_RST_HYST 16'h0000
`define CPD_CNT_MAX 32'hffff_ffff
`define CPD_RUN_ONE 17'h0_0001
`define CPD_RUN_MAX 17'h1_ffff

// Bus responses
`define CPD_RESP_OKAY 2'b00
`define CPD_RESP_SLVERR 2'b10

`endif

// file: shared/cpd_pkg.sv
// Types of the counter preset and direction detection block
package cpd_pkg;

	// Which armed source owns the pending preset
	typedef enum logic [1:0] {
		OWN_NONE,
		OWN_SW,
		OWN_ZERO,
		OWN_EXT
	} cpd_owner_t;

	// Software-written control bits
	typedef struct packed {
		logic dir_inv;
		logic fall_arm;
		logic rise_arm;
		logic zero_arm;
		logic sw_cmd;
	} cpd_ctrl_t;

	// Complete state of the block
	typedef struct packed {
		logic [1:0] sync_zero;
		logic [1:0] sync_latch;
		logic zero_last;
		logic latch_last;
		logic [31:0] count;
		logic [31:0] preset_val;
		logic [15:0] hyst;
		cpd_ctrl_t ctrl;
		cpd_owner_t owner;
		logic done;
		logic [31:0] prev_pos;
		logic have_prev;
		logic ovf_seen;
		logic unf_seen;
		logic dir_flag;
		logic run_valid;
		logic run_dir;
		logic [16:0] run_len;
		logic inv_pending;
		logic inv_seen;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} cpd_state_t;

endpackage

// file: design/cpd_core.sv
// Encoder channel: position counter with preset and direction detection
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`include "cpd_defs.svh"

module cpd_core
	import cpd_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// Counting steps from the track decoder, same clock
	input wire logic step,
	input wire logic step_down,
	// Control-cycle strobe, same clock
	input wire logic cycle_strobe,
	// Asynchronous pins
	input wire logic zero_pulse_pin,
	input wire logic latch_pin,
	// Status outputs
	output logic [31:0] count_value,
	output logic preset_done,
	output logic dir_flag,
	// AXI4-Lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	// AXI4-Lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	// AXI4-Lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);

	cpd_state_t s_reg;
	cpd_state_t s_next;

	// Operating notes for users of this channel
	// Preset sources are armed by control bits; ownership is taken one
	// clock after the arm bit is registered, so a tie inside one write
	// resolves by fixed priority: software, then zero pulse, then latch.
	// A source that loses keeps its arm bit but, once the winner has loaded, is not acted upon
	// until every arm bit has dropped and the done flag has cleared.
	// The done flag is set by a load and cleared one clock after all
	// arm bits read false; a load in that same clock wins over the clear.
	// Releasing an owner's arm bit before its event gives up ownership
	// without a load, and a waiting source may then take over.
	// Pin events pass two synchroniser stages plus an edge register, so
	// a pin pulse must stand at least one clock to be seen at all.
	// Both latch polarities may be armed together; either edge loads.
	// The counter steps once per step pulse; a load in the same clock
	// wins and the step is lost, which matches a preset overwriting it.
	// Wrap flags live for one control cycle only and freeze the sign
	// result of that cycle; the previous position is still resampled.
	// With hysteresis zero the flag follows the sign of the difference, flipped when count inversion is set.
	// With hysteresis above zero the flag reports a qualified reversal.
	// A reversal qualifies once the run after it exceeds the hysteresis.
	// Run length saturates, so a very long run cannot wrap to zero.
	// Count inversion flips the step direction before run tracking, so
	// reversal results are the same either way; only the sign changes.
	// All run-tracking and wrap state except the run direction is cleared at each control-cycle boundary.
	// The control strobe must be a single-clock pulse on this clock;
	// a longer strobe would evaluate several times in one cycle.
	// The register bus takes address and data in either order and
	// answers one clock after the later of the two is taken.
	// While a response is pending no new write is accepted, and while
	// read data is pending no new read address is accepted.
	// The clock enable freezes every register, including the bus side;
	// ready outputs drop with it so no transfer is half taken.
	// Writes to read-only registers answer OKAY and change nothing.
	// Unmapped offsets answer SLVERR; reads of them return zero.
	// Control writes use byte lane 0 only; hysteresis uses lanes 0-1.

	// Byte-lane merge of a register write
	function automatic logic [31:0] merge_bytes(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0] strb
	);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Handshake outputs, gated by the enable so nothing is taken while frozen
	assign awready = ce & ~s_reg.aw_held & ~s_reg.bvalid;
	assign wready = ce & ~s_reg.w_held & ~s_reg.bvalid;
	assign arready = ce & ~s_reg.rvalid;

	// Registered outputs
	assign bvalid = s_reg.bvalid;
	assign bresp = s_reg.bresp;
	assign rvalid = s_reg.rvalid;
	assign rdata = s_reg.rdata;
	assign rresp = s_reg.rresp;
	assign count_value = s_reg.count;
	assign preset_done = s_reg.done;
	assign dir_flag = s_reg.dir_flag;

	// Next-state logic of the whole block
	always_comb begin
		logic zero_evt;
		logic rise_evt;
		logic fall_evt;
		logic any_arm;
		logic load;
		logic ext_hit;
		logic [31:0] diff;
		logic d;
		logic aw_ok;
		logic w_ok;
		logic [7:0] wa;
		logic [31:0] wd;
		logic [3:0] ws;
		logic [7:0] ra;
		zero_evt = 1'b0;
		rise_evt = 1'b0;
		fall_evt = 1'b0;
		any_arm = 1'b0;
		load = 1'b0;
		ext_hit = 1'b0;
		diff = `CPD_RST_WORD;
		d = 1'b0;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		wa = awaddr;
		wd = wdata;
		ws = wstrb;
		ra = araddr;
		s_next = s_reg;

		// Pin synchronisers; only the second stage is looked at
		s_next.sync_zero = {s_reg.sync_zero[0], zero_pulse_pin};
		s_next.sync_latch = {s_reg.sync_latch[0], latch_pin};
		s_next.zero_last = s_reg.sync_zero[1];
		s_next.latch_last = s_reg.sync_latch[1];
		zero_evt = s_reg.sync_zero[1] & ~s_reg.zero_last;
		rise_evt = s_reg.sync_latch[1] & ~s_reg.latch_last;
		fall_evt = ~s_reg.sync_latch[1] & s_reg.latch_last;

		any_arm = s_reg.ctrl.sw_cmd | s_reg.ctrl.zero_arm |
			s_reg.ctrl.rise_arm | s_reg.ctrl.fall_arm;

		// Preset ownership: first armed source wins, others wait
		case (s_reg.owner)
			OWN_NONE: begin
				if (!s_reg.done) begin
					if (s_reg.ctrl.sw_cmd) begin
						s_next.owner = OWN_SW;
					end else if (s_reg.ctrl.zero_arm) begin
						s_next.owner = OWN_ZERO;
					end else if (s_reg.ctrl.rise_arm | s_reg.ctrl.fall_arm) begin
						s_next.owner = OWN_EXT;
					end
				end
			end
			OWN_SW: begin
				if (s_reg.ctrl.sw_cmd) begin
					load = 1'b1;
				end else begin
					s_next.owner = OWN_NONE;
				end
			end
			OWN_ZERO: begin
				if (!s_reg.ctrl.zero_arm) begin
					s_next.owner = OWN_NONE;
				end else if (zero_evt) begin
					load = 1'b1;
				end
			end
			OWN_EXT: begin
				ext_hit = (s_reg.ctrl.rise_arm & rise_evt) |
					(s_reg.ctrl.fall_arm & fall_evt);
				if (!(s_reg.ctrl.rise_arm | s_reg.ctrl.fall_arm)) begin
					s_next.owner = OWN_NONE;
				end else if (ext_hit) begin
					load = 1'b1;
				end
			end
			default: begin
				s_next.owner = OWN_NONE;
			end
		endcase

		// Load then lock until every arm bit is back to false
		if (load) begin
			s_next.done = 1'b1;
			s_next.owner = OWN_NONE;
		end else if (s_reg.done && !any_arm) begin
			s_next.done = 1'b0;
		end

		// Position counter; preset overrides a step
		if (load) begin
			s_next.count = s_reg.preset_val;
		end else if (step) begin
			if (step_down ^ s_reg.ctrl.dir_inv) begin
				if (s_reg.count == `CPD_RST_WORD) begin
					s_next.unf_seen = 1'b1;
				end
				s_next.count = s_reg.count - 32'h0000_0001;
			end else begin
				if (s_reg.count == `CPD_CNT_MAX) begin
					s_next.ovf_seen = 1'b1;
				end
				s_next.count = s_reg.count + 32'h0000_0001;
			end
		end

		// Run tracking of consecutive edges for reversal mode
		if (step) begin
			d = step_down ^ s_reg.ctrl.dir_inv;
			if (!s_reg.run_valid) begin
				s_next.run_valid = 1'b1;
				s_next.run_dir = d;
				s_next.run_len = `CPD_RUN_ONE;
			end else if (d == s_reg.run_dir) begin
				if (s_reg.run_len != `CPD_RUN_MAX) begin
					s_next.run_len = s_reg.run_len + `CPD_RUN_ONE;
				end
			end else begin
				s_next.run_dir = d;
				s_next.run_len = `CPD_RUN_ONE;
				s_next.inv_pending = 1'b1;
			end
		end
		if (s_next.inv_pending && s_next.run_len > {1'b0, s_reg.hyst}) begin
			s_next.inv_seen = 1'b1;
		end

		// Control-cycle boundary: sample position and publish the flag
		if (cycle_strobe) begin
			diff = s_reg.count - s_reg.prev_pos;
			s_next.prev_pos = s_reg.count;
			s_next.have_prev = 1'b1;
			if (s_reg.hyst == `CPD_RST_HYST) begin
				if (!s_reg.have_prev) begin
					s_next.dir_flag = 1'b0;
				end else if (s_reg.ovf_seen | s_reg.unf_seen) begin
					s_next.dir_flag = s_reg.dir_flag;
				end else if (diff != `CPD_RST_WORD) begin
					s_next.dir_flag = diff[31] ^ s_reg.ctrl.dir_inv;
				end
			end else begin
				s_next.dir_flag = s_next.inv_seen;
			end
			// Hysteresis evaluation never spans a boundary
			s_next.run_valid = 1'b0;
			s_next.run_len = 17'h0_0000;
			s_next.inv_pending = 1'b0;
			s_next.inv_seen = 1'b0;
			s_next.ovf_seen = 1'b0;
			s_next.unf_seen = 1'b0;
		end

		// Write channel capture in either order
		if (awvalid && awready) begin
			s_next.aw_held = 1'b1;
			s_next.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			s_next.w_held = 1'b1;
			s_next.w_data = wdata;
			s_next.w_strb = wstrb;
		end
		aw_ok = s_next.aw_held;
		w_ok = s_next.w_held;
		wa = s_next.aw_addr;
		wd = s_next.w_data;
		ws = s_next.w_strb;

		// Register write once address and data are both present
		if (aw_ok && w_ok && !s_reg.bvalid) begin
			s_next.aw_held = 1'b0;
			s_next.w_held = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = `CPD_RESP_OKAY;
			case ({wa[7:2], 2'b00})
				`CPD_OFS_CTRL: begin
					if (ws[0]) begin
						s_next.ctrl = wd[4:0];
					end
				end
				`CPD_OFS_PRESET: begin
					s_next.preset_val = merge_bytes(s_reg.preset_val, wd, ws);
				end
				`CPD_OFS_HYST: begin
					if (ws[0]) begin
						s_next.hyst[7:0] = wd[7:0];
					end
					if (ws[1]) begin
						s_next.hyst[15:8] = wd[15:8];
					end
				end
				`CPD_OFS_STATUS, `CPD_OFS_COUNT: begin
					s_next.bresp = `CPD_RESP_OKAY;
				end
				default: begin
					s_next.bresp = `CPD_RESP_SLVERR;
				end
			endcase
		end
		if (s_reg.bvalid && bready) begin
			s_next.bvalid = 1'b0;
		end

		// Register read
		if (arvalid && arready) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = `CPD_RESP_OKAY;
			s_next.rdata = `CPD_RST_WORD;
			case ({ra[7:2], 2'b00})
				`CPD_OFS_CTRL: begin
					s_next.rdata[4:0] = s_reg.ctrl;
				end
				`CPD_OFS_PRESET: begin
					s_next.rdata = s_reg.preset_val;
				end
				`CPD_OFS_HYST: begin
					s_next.rdata[15:0] = s_reg.hyst;
				end
				`CPD_OFS_STATUS: begin
					s_next.rdata[`CPD_ST_DONE] = s_reg.done;
					s_next.rdata[`CPD_ST_DIR] = s_reg.dir_flag;
					s_next.rdata[`CPD_ST_OVF] = s_reg.ovf_seen;
					s_next.rdata[`CPD_ST_UNF] = s_reg.unf_seen;
				end
				`CPD_OFS_COUNT: begin
					s_next.rdata = s_reg.count;
				end
				default: begin
					s_next.rresp = `CPD_RESP_SLVERR;
				end
			endcase
		end else if (s_reg.rvalid && rready) begin
			s_next.rvalid = 1'b0;
		end
	end

	// State register with synchronous reset and clock enable
	always_ff @(posedge clk) begin
		if (reset) begin
			s_reg <= '0;
			s_reg.hyst <= `CPD_RST_HYST;
			s_reg.preset_val <= `CPD_RST_WORD;
			s_reg.owner <= OWN_NONE;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

endmodule

// file: tb/cpd_core_props.sv
// Port-level checks of the preset and direction block
`timescale 1ns/100ps
module cpd_core_props (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Counter side
	input wire logic step,
	input wire logic cycle_strobe,
	input wire logic [31:0] count_value,
	input wire logic preset_done,
	input wire logic dir_flag,
	// Bus handshakes
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_dir_at_strobe: assert property (!$past(cycle_strobe) && !$past(reset)
		|-> $stable(dir_flag)) else $error("dir flag moved off strobe");
	a_count_cause: assert property ($changed(count_value) |-> $past(step)
		|| $rose(preset_done) || $past(reset)) else $error("count moved alone");
	a_b_hold: assert property (bvalid && !bready |=> bvalid
		&& $stable(bresp)) else $error("write answer dropped");
	a_r_hold: assert property (rvalid && !rready |=> rvalid
		&& $stable(rdata)) else $error("read answer dropped");
	a_no_aw: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answering");
	a_no_ar: assert property (rvalid |-> !arready)
		else $error("read taken while answering");
	a_b_soon: assert property (awvalid && awready && wvalid && wready
		|=> bvalid) else $error("write answer late");
	a_r_soon: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
endmodule
bind cpd_core cpd_core_props u_props (.clk, .reset, .step, .cycle_strobe,
	.count_value, .preset_done, .dir_flag, .awvalid, .awready, .wvalid,
	.wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid,
	.rready, .rdata);

// file: tb/cpd_enc_model.sv
// Encoder tracks, pins and control-cycle strobe driving the channel
`timescale 1ns/100ps
module cpd_enc_model (
	// Clock
	input wire logic clk,
	// Encoder, pins and controller strobe
	output logic step,
	output logic step_down,
	output logic cycle_strobe,
	output logic zero_pulse_pin,
	output logic latch_pin
);
	// Idle levels at time zero
	initial begin
		step = 1'b0;
		step_down = 1'b0;
		cycle_strobe = 1'b0;
		zero_pulse_pin = 1'b0;
		latch_pin = 1'b0;
	end
	// Run of steps in one direction, one per clock
	task automatic move(input int n, input logic down);
		repeat (n) begin
			@(posedge clk);
			step <= 1'b1;
			step_down <= down;
		end
		@(posedge clk);
		step <= 1'b0;
	endtask
	// One control-cycle boundary, then settle
	task automatic tick();
		@(posedge clk);
		cycle_strobe <= 1'b1;
		@(posedge clk);
		cycle_strobe <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	// Zero pulse long enough for the synchroniser
	task automatic zero();
		@(posedge clk);
		zero_pulse_pin <= 1'b1;
		repeat (3) @(posedge clk);
		zero_pulse_pin <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	// Latch pin to a new level
	task automatic latch(input logic v);
		@(posedge clk);
		latch_pin <= v;
		repeat (8) @(posedge clk);
	endtask
endmodule

// file: tb/test_cpd_core.sv
// Register-level tests of the preset and direction block
`timescale 1ns/100ps
`include "cpd_defs.svh"
module test_cpd_core;
	logic clk = 0, reset = 1, ce = 1;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, count_value, rdata, d;
	logic [3:0] wstrb = 0;
	logic [1:0] bresp, rresp, r;
	logic step, step_down, cycle_strobe, zero_pulse_pin, latch_pin;
	logic awready, wready, arready, bvalid, rvalid, preset_done, dir_flag;
	int errors = 0, checked = 0;
	// Clock, 40 ns
	always #20 clk = ~clk;
	cpd_enc_model enc (.clk, .step, .step_down, .cycle_strobe,
		.zero_pulse_pin, .latch_pin);
	cpd_core dut (.clk, .reset, .ce, .step, .step_down,
		.cycle_strobe, .zero_pulse_pin, .latch_pin, .count_value,
		.preset_done, .dir_flag, .awvalid, .awready, .awaddr,
		.awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid,
		.bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
		.rvalid, .rready, .rdata, .rresp);
	// Compare and count
	task automatic chk(input string s, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	// Bus write; bready held until the answer is sampled
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic pa, pw;
		pa = 1;
		pw = 1;
		@(posedge clk);
		awvalid <= 1;
		awaddr <= a;
		wvalid <= 1;
		wdata <= v;
		wstrb <= 4'hf;
		bready <= 1;
		while (pa || pw) begin
			@(posedge clk);
			if (pa && awready) begin
				pa = 0;
				awvalid <= 0;
			end
			if (pw && wready) begin
				pw = 0;
				wvalid <= 0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 0;
	endtask
	// Bus read; rready held until the answer is sampled
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		arvalid <= 1;
		araddr <= a;
		rready <= 1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 0;
	endtask
	// Status bits dir and done
	task automatic st(input logic [31:0] e);
		rd(`CPD_OFS_STATUS);
		chk("status", e, d & 32'h3);
	endtask
	task automatic cnt(input logic [31:0] e);
		rd(`CPD_OFS_COUNT);
		chk("count", e, d);
	endtask
	task automatic tally_and_finish();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Watchdog
	initial begin
		#(40 * 20000);
		errors++;
		tally_and_finish();
	end
	// Test sequence
	initial begin
		repeat (5) @(posedge clk);
		reset <= 0;
		st(0);
		cnt(0);
		rd(8'h40);
		chk("rresp", `CPD_RESP_SLVERR, r);
		wr(8'h40, 1);
		chk("bresp", `CPD_RESP_SLVERR, r);
		$display("test reset and map done");
		wr(`CPD_OFS_PRESET, 32'h1234_5678);
		wr(`CPD_OFS_CTRL, 32'h1);
		cnt(32'h1234_5678);
		st(1);
		wr(`CPD_OFS_PRESET, 32'h10);
		wr(`CPD_OFS_CTRL, 32'h1);
		cnt(32'h1234_5678);
		wr(`CPD_OFS_CTRL, 0);
		st(0);
		$display("test software preset done");
		wr(`CPD_OFS_CTRL, 32'h6);
		enc.latch(1);
		cnt(32'h1234_5678);
		enc.zero();
		cnt(32'h10);
		wr(`CPD_OFS_CTRL, 0);
		st(0);
		wr(`CPD_OFS_PRESET, 32'h55);
		enc.latch(0);
		wr(`CPD_OFS_CTRL, 32'h8);
		enc.latch(1);
		cnt(32'h10);
		enc.latch(0);
		cnt(32'h55);
		wr(`CPD_OFS_CTRL, 0);
		st(0);
		$display("test triggered presets done");
		enc.tick();
		st(0);
		enc.move(3, 0);
		enc.tick();
		st(0);
		enc.move(2, 1);
		enc.tick();
		st(2);
		enc.tick();
		st(2);
		wr(`CPD_OFS_CTRL, 32'h10);
		enc.move(1, 0);
		enc.tick();
		st(0);
		cnt(32'h55);
		wr(`CPD_OFS_CTRL, 0);
		wr(`CPD_OFS_PRESET, 0);
		wr(`CPD_OFS_CTRL, 32'h2);
		enc.zero();
		enc.tick();
		wr(`CPD_OFS_CTRL, 0);
		st(2);
		enc.move(1, 0);
		enc.tick();
		enc.move(2, 1);
		enc.tick();
		st(0);
		cnt(32'hffff_ffff);
		enc.move(1, 1);
		enc.tick();
		st(2);
		$display("test sign detection done");
		wr(`CPD_OFS_HYST, 2);
		enc.tick();
		enc.move(2, 0);
		enc.move(3, 1);
		enc.tick();
		st(2);
		enc.tick();
		st(0);
		enc.move(1, 0);
		enc.move(2, 1);
		enc.tick();
		st(0);
		enc.move(1, 0);
		enc.move(3, 1);
		enc.move(3, 0);
		enc.tick();
		st(2);
		wr(`CPD_OFS_HYST, 1);
		enc.tick();
		enc.move(1, 0);
		enc.move(2, 1);
		enc.tick();
		st(2);
		@(posedge clk);
		ce <= 0;
		enc.move(2, 0);
		ce <= 1;
		cnt(32'hffff_fffc);
		$display("test reversal detection done");
		tally_and_finish();
	end
endmodule
